// File: logic/timer16_pkg.sv
// constants and types shared by the 16-bit timer block
package timer16_pkg;

   // register byte addresses on the wishbone bus
   localparam logic [3:0] ADR_CTL_A = 4'h0;
   localparam logic [3:0] ADR_CTL_B = 4'h1;
   localparam logic [3:0] ADR_CTL_C = 4'h2;
   localparam logic [3:0] ADR_CNT_LO = 4'h3;
   localparam logic [3:0] ADR_CNT_HI = 4'h4;
   localparam logic [3:0] ADR_CAP_LO = 4'h5;
   localparam logic [3:0] ADR_CAP_HI = 4'h6;
   localparam logic [3:0] ADR_CMPA_LO = 4'h7;
   localparam logic [3:0] ADR_CMPA_HI = 4'h8;
   localparam logic [3:0] ADR_CMPB_LO = 4'h9;
   localparam logic [3:0] ADR_CMPB_HI = 4'ha;
   localparam logic [3:0] ADR_FLAGS = 4'hb;
   localparam logic [3:0] ADR_MASK = 4'hc;
   localparam logic [3:0] ADR_POWER = 4'hd;

   // field positions
   localparam int CTLA_COMB = 4;
   localparam int CTLA_COMA = 6;
   localparam int CTLB_WGM2 = 3;
   localparam int CTLB_WGM3 = 4;
   localparam int CTLB_EDGE = 6;
   localparam int CTLB_FILT = 7;
   localparam int CTLC_SRC = 0;
   localparam int CTLC_FORCE_B = 6;
   localparam int CTLC_FORCE_A = 7;
   localparam int FLAG_OVF = 0;
   localparam int FLAG_MA = 1;
   localparam int FLAG_MB = 2;
   localparam int FLAG_CAP = 5;
   localparam int PWR_OFF = 0;

   // count landmarks
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX = 16'hffff;
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;

   // prescaler and capture filter
   localparam int PRE_W = 10;
   localparam int FILTER_LEN = 4;

   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } clock_sel_type;

   typedef enum logic [2:0] {
      KIND_NORMAL = 3'h0, KIND_CTC = 3'h1, KIND_FAST = 3'h2, KIND_PC = 3'h3, KIND_PFC = 3'h4
   } mode_kind_type;

   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic cap_src;
      logic [7:0] mask;
      logic [7:0] flags;
      logic pwr_off;
      logic [7:0] temp;
      logic [15:0] count;
      logic [15:0] cap;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] buf_a;
      logic [15:0] buf_b;
      logic count_down;
      logic block_match;
      logic [PRE_W-1:0] pre;
      logic [1:0] ext_sync;
      logic ext_prev;
      logic [1:0] capp_sync;
      logic [1:0] cmpin_sync;
      logic [FILTER_LEN-1:0] filt;
      logic cap_level;
      logic cap_prev;
      logic wave_a;
      logic wave_b;
      logic [3:0] irq;
      logic ack;
      logic [7:0] dat;
   } timer_state_type;

endpackage

// File: logic/timer16.sv
// 16-bit timer with two compare units, one capture unit and a wishbone slave
//
// Functional notes
// - no clock source selected: counter holds
// - tick from prescaler or chosen pin edge
// - compare registers checked on every tick but the first after a counter write
// - counter equal compare sets match flag
// - compare result drives wave output pins
// - capture edge copies counter into capture unless capture is top
// - optional noise filter on capture trigger
// - top from fixed values, compare or capture
// - bottom is 0x0000
// - max is 0xffff
// - compare-a as top gives no pwm
// - compare-a top double buffered in pwm
// - capture register selectable as top
// - four flags, four mask bits
// - 16-bit registers via shared high latch
// - control registers plain 8-bit access
// - control c forces, b holds mode bits 2 and 3
// - low mode bits keep legacy positions
// - low byte write moves whole word; low byte read of counter or capture loads the high latch
// - cpu counter write beats counting
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module timer16 (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [3:0] ADR_I,
   input wire logic SEL_I,
   input wire logic [7:0] DAT_I,
   output logic [7:0] DAT_O,
   output logic ACK_O,
   input wire logic EXT_COUNT_PIN,
   input wire logic CAPTURE_PIN,
   input wire logic COMPARATOR_IN,
   output logic WAVE_OUT_A,
   output logic WAVE_OUT_B,
   output logic IRQ_OVERFLOW,
   output logic IRQ_MATCH_A,
   output logic IRQ_MATCH_B,
   output logic IRQ_CAPTURE
);

   timer16_pkg::timer_state_type r;
   timer16_pkg::timer_state_type n;

   logic req;
   logic wr;
   logic rd;
   logic [3:0] wgm;
   timer16_pkg::mode_kind_type kind;
   logic pwm;
   logic [15:0] top;
   logic at_top;
   logic at_bot;
   logic tick;
   logic match_a;
   logic match_b;
   logic wrap;
   logic ocra_top;
   logic top_from_cap;
   logic force_a;
   logic force_b;
   logic cap_raw;
   logic cap_edge;
   logic count_wr;

   // mode number split over two registers, legacy bit positions kept
   function automatic timer16_pkg::mode_kind_type kind_of(input logic [3:0] m);
      case (m)
         4'h4, 4'hc: kind_of = timer16_pkg::KIND_CTC;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = timer16_pkg::KIND_FAST;
         4'h1, 4'h2, 4'h3, 4'ha, 4'hb: kind_of = timer16_pkg::KIND_PC;
         4'h8, 4'h9: kind_of = timer16_pkg::KIND_PFC;
         default: kind_of = timer16_pkg::KIND_NORMAL;
      endcase
   endfunction

   // highest count value per mode
   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca, input logic [15:0] ic);
      case (m)
         4'h1, 4'h5: top_of = timer16_pkg::TOP_8;
         4'h2, 4'h6: top_of = timer16_pkg::TOP_9;
         4'h3, 4'h7: top_of = timer16_pkg::TOP_10;
         4'h4, 4'h9, 4'hb, 4'hf: top_of = ca;
         4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
         default: top_of = timer16_pkg::MAX;
      endcase
   endfunction

   // timer tick from prescaler taps or synchronised pin edges
   function automatic logic tick_of(input logic [2:0] cs, input logic [timer16_pkg::PRE_W-1:0] p,
                                    input logic rise, input logic fall);
      case (cs)
         timer16_pkg::CS_DIV1: tick_of = 1'b1;
         timer16_pkg::CS_DIV8: tick_of = &p[2:0];
         timer16_pkg::CS_DIV64: tick_of = &p[5:0];
         timer16_pkg::CS_DIV256: tick_of = &p[7:0];
         timer16_pkg::CS_DIV1024: tick_of = &p[9:0];
         timer16_pkg::CS_EXT_FALL: tick_of = fall;
         timer16_pkg::CS_EXT_RISE: tick_of = rise;
         default: tick_of = 1'b0;
      endcase
   endfunction

   // next level of one wave output
   function automatic logic wave_step(input logic cur, input logic [1:0] com, input timer16_pkg::mode_kind_type k,
                                      input logic hit, input logic wrp, input logic down, input logic top_is_me);
      wave_step = cur;
      if (com == 2'h0)
      begin
         wave_step = 1'b0;
      end
      else if (k == timer16_pkg::KIND_NORMAL || k == timer16_pkg::KIND_CTC)
      begin
         if (hit)
         begin
            wave_step = (com == 2'h1) ? ~cur : com[0];
         end
      end
      else if (com == 2'h1)
      begin
         if (hit && top_is_me)
         begin
            wave_step = ~cur;
         end
      end
      else if (!top_is_me)
      begin
         if (k == timer16_pkg::KIND_FAST)
         begin
            if (wrp)
            begin
               wave_step = ~com[0];
            end
            else if (hit)
            begin
               wave_step = com[0];
            end
         end
         else if (hit)
         begin
            wave_step = down ? ~com[0] : com[0];
         end
      end
   endfunction

   // bus request decode, one ack per request
   assign req = CYC_I & STB_I & ~r.ack;
   assign wr = req & WE_I & SEL_I;
   assign rd = req & ~WE_I;
   assign count_wr = wr && (ADR_I == timer16_pkg::ADR_CNT_LO);

   // mode, top and landmarks
   assign wgm = {r.ctl_b[timer16_pkg::CTLB_WGM3], r.ctl_b[timer16_pkg::CTLB_WGM2], r.ctl_a[1:0]};
   assign kind = kind_of(wgm);
   assign pwm = (kind == timer16_pkg::KIND_FAST) || (kind == timer16_pkg::KIND_PC) || (kind == timer16_pkg::KIND_PFC);
   assign top = top_of(wgm, r.cmp_a, r.cap);
   assign ocra_top = (wgm == 4'h9) || (wgm == 4'hb) || (wgm == 4'hf);
   assign top_from_cap = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
   assign at_top = (r.count == top);
   assign at_bot = (r.count == timer16_pkg::BOTTOM);

   // timer tick, held off while powered down or stopped
   assign tick = ~r.pwr_off & tick_of(r.ctl_b[2:0], r.pre, r.ext_sync[1] & ~r.ext_prev,
                                      ~r.ext_sync[1] & r.ext_prev);

   // continuous compare on every tick but the first after a counter write
   assign match_a = tick & ~r.block_match & (r.count == r.cmp_a);
   assign match_b = tick & ~r.block_match & (r.count == r.cmp_b);
   assign wrap = tick & (kind == timer16_pkg::KIND_FAST) & at_top;
   assign force_a = wr && (ADR_I == timer16_pkg::ADR_CTL_C) && DAT_I[timer16_pkg::CTLC_FORCE_A] && !pwm;
   assign force_b = wr && (ADR_I == timer16_pkg::ADR_CTL_C) && DAT_I[timer16_pkg::CTLC_FORCE_B] && !pwm;

   // capture trigger source and edge on the filtered level
   assign cap_raw = r.cap_src ? r.cmpin_sync[1] : r.capp_sync[1];
   assign cap_edge = r.ctl_b[timer16_pkg::CTLB_EDGE] ? (r.cap_level & ~r.cap_prev) : (~r.cap_level & r.cap_prev);

   // next state of the whole block
   always_comb
   begin
      logic [7:0] set;
      logic [7:0] clr;
      logic upd;
      set = 8'h00;
      clr = 8'h00;
      upd = 1'b0;
      n = r;
      n.ack = req;
      n.dat = 8'h00;
      n.pre = r.pre + 10'h001;
      n.ext_sync = {r.ext_sync[0], EXT_COUNT_PIN};
      n.ext_prev = r.ext_sync[1];
      n.capp_sync = {r.capp_sync[0], CAPTURE_PIN};
      n.cmpin_sync = {r.cmpin_sync[0], COMPARATOR_IN};

      // counter sequence per mode kind
      if (tick)
      begin
         n.block_match = 1'b0;
         case (kind)
            timer16_pkg::KIND_FAST:
            begin
               if (at_top)
               begin
                  n.count = timer16_pkg::BOTTOM;
                  set[timer16_pkg::FLAG_OVF] = 1'b1;
                  upd = 1'b1;
               end
               else
               begin
                  n.count = r.count + 16'h0001;
               end
            end
            timer16_pkg::KIND_PC, timer16_pkg::KIND_PFC:
            begin
               if (!r.count_down)
               begin
                  if (at_top)
                  begin
                     n.count_down = 1'b1;
                     n.count = r.count - 16'h0001;
                     upd = (kind == timer16_pkg::KIND_PC);
                  end
                  else
                  begin
                     n.count = r.count + 16'h0001;
                  end
               end
               else if (at_bot)
               begin
                  n.count_down = 1'b0;
                  n.count = r.count + 16'h0001;
                  set[timer16_pkg::FLAG_OVF] = 1'b1;
                  upd = (kind == timer16_pkg::KIND_PFC);
               end
               else
               begin
                  n.count = r.count - 16'h0001;
               end
            end
            timer16_pkg::KIND_CTC:
            begin
               n.count = at_top ? timer16_pkg::BOTTOM : r.count + 16'h0001;
               set[timer16_pkg::FLAG_OVF] = (r.count == timer16_pkg::MAX);
            end
            default:
            begin
               n.count = r.count + 16'h0001;
               set[timer16_pkg::FLAG_OVF] = (r.count == timer16_pkg::MAX);
            end
         endcase
      end

      // compare flags and wave outputs
      set[timer16_pkg::FLAG_MA] = match_a;
      set[timer16_pkg::FLAG_MB] = match_b;
      n.wave_a = wave_step(r.wave_a, r.ctl_a[timer16_pkg::CTLA_COMA +: 2], kind, match_a | force_a, wrap,
                           r.count_down, ocra_top);
      n.wave_b = wave_step(r.wave_b, r.ctl_a[timer16_pkg::CTLA_COMB +: 2], kind, match_b | force_b, wrap,
                           r.count_down, 1'b0);

      // compare buffers: immediate outside pwm, loaded at the update point in pwm
      if (!pwm || upd)
      begin
         n.cmp_a = r.buf_a;
         n.cmp_b = r.buf_b;
      end

      // capture filter and capture event
      n.filt = {r.filt[timer16_pkg::FILTER_LEN-2:0], cap_raw};
      if (!r.ctl_b[timer16_pkg::CTLB_FILT])
      begin
         n.cap_level = cap_raw;
      end
      else if (&r.filt)
      begin
         n.cap_level = 1'b1;
      end
      else if (~|r.filt)
      begin
         n.cap_level = 1'b0;
      end
      n.cap_prev = r.cap_level;
      if (cap_edge && !top_from_cap)
      begin
         n.cap = r.count;
         set[timer16_pkg::FLAG_CAP] = 1'b1;
      end

      // register reads; low byte of counter and capture loads the latch
      if (rd)
      begin
         if (ADR_I == timer16_pkg::ADR_CTL_A)
         begin
            n.dat = r.ctl_a;
         end
         else if (ADR_I == timer16_pkg::ADR_CTL_B)
         begin
            n.dat = r.ctl_b;
         end
         else if (ADR_I == timer16_pkg::ADR_CTL_C)
         begin
            n.dat = {7'h00, r.cap_src};
         end
         else if (ADR_I == timer16_pkg::ADR_CNT_LO)
         begin
            n.dat = r.count[7:0];
            n.temp = r.count[15:8];
         end
         else if (ADR_I == timer16_pkg::ADR_CAP_LO)
         begin
            n.dat = r.cap[7:0];
            n.temp = r.cap[15:8];
         end
         else if (ADR_I == timer16_pkg::ADR_CNT_HI || ADR_I == timer16_pkg::ADR_CAP_HI)
         begin
            n.dat = r.temp;
         end
         else if (ADR_I == timer16_pkg::ADR_CMPA_LO)
         begin
            n.dat = r.buf_a[7:0];
         end
         else if (ADR_I == timer16_pkg::ADR_CMPA_HI)
         begin
            n.dat = r.buf_a[15:8];
         end
         else if (ADR_I == timer16_pkg::ADR_CMPB_LO)
         begin
            n.dat = r.buf_b[7:0];
         end
         else if (ADR_I == timer16_pkg::ADR_CMPB_HI)
         begin
            n.dat = r.buf_b[15:8];
         end
         else if (ADR_I == timer16_pkg::ADR_FLAGS)
         begin
            n.dat = r.flags;
         end
         else if (ADR_I == timer16_pkg::ADR_MASK)
         begin
            n.dat = r.mask;
         end
         else if (ADR_I == timer16_pkg::ADR_POWER)
         begin
            n.dat = {7'h00, r.pwr_off};
         end
      end

      // register writes; low byte write moves latch and data together
      if (wr)
      begin
         if (ADR_I == timer16_pkg::ADR_CTL_A)
         begin
            n.ctl_a = DAT_I;
         end
         else if (ADR_I == timer16_pkg::ADR_CTL_B)
         begin
            n.ctl_b = DAT_I;
         end
         else if (ADR_I == timer16_pkg::ADR_CTL_C)
         begin
            n.cap_src = DAT_I[timer16_pkg::CTLC_SRC];
         end
         else if (ADR_I == timer16_pkg::ADR_CNT_HI || ADR_I == timer16_pkg::ADR_CAP_HI ||
                  ADR_I == timer16_pkg::ADR_CMPA_HI || ADR_I == timer16_pkg::ADR_CMPB_HI)
         begin
            n.temp = DAT_I;
         end
         else if (ADR_I == timer16_pkg::ADR_CNT_LO)
         begin
            n.count = {r.temp, DAT_I};
            n.block_match = 1'b1;
         end
         else if (ADR_I == timer16_pkg::ADR_CAP_LO)
         begin
            n.cap = {r.temp, DAT_I};
         end
         else if (ADR_I == timer16_pkg::ADR_CMPA_LO)
         begin
            n.buf_a = {r.temp, DAT_I};
         end
         else if (ADR_I == timer16_pkg::ADR_CMPB_LO)
         begin
            n.buf_b = {r.temp, DAT_I};
         end
         else if (ADR_I == timer16_pkg::ADR_FLAGS)
         begin
            clr = DAT_I;
         end
         else if (ADR_I == timer16_pkg::ADR_MASK)
         begin
            n.mask = DAT_I;
         end
         else if (ADR_I == timer16_pkg::ADR_POWER)
         begin
            n.pwr_off = DAT_I[timer16_pkg::PWR_OFF];
         end
      end

      // flags: hardware set wins over a write-one clear
      n.flags = (r.flags & ~clr) | set;
      n.irq = {n.flags[timer16_pkg::FLAG_CAP] & n.mask[timer16_pkg::FLAG_CAP],
               n.flags[timer16_pkg::FLAG_MB] & n.mask[timer16_pkg::FLAG_MB],
               n.flags[timer16_pkg::FLAG_MA] & n.mask[timer16_pkg::FLAG_MA],
               n.flags[timer16_pkg::FLAG_OVF] & n.mask[timer16_pkg::FLAG_OVF]};
   end

   // state register
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   // outputs straight from the state register
   assign DAT_O = r.dat;
   assign ACK_O = r.ack;
   assign WAVE_OUT_A = r.wave_a;
   assign WAVE_OUT_B = r.wave_b;
   assign IRQ_OVERFLOW = r.irq[0];
   assign IRQ_MATCH_A = r.irq[1];
   assign IRQ_MATCH_B = r.irq[2];
   assign IRQ_CAPTURE = r.irq[3];

   // checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   AST_STOPPED_HOLDS: assert property ((r.ctl_b[2:0] == 3'h0) && !count_wr |=> r.count == $past(r.count))
      else $error("counter moved with no clock source");
   AST_STEP_ONLY_ON_TICK: assert property (!tick && !count_wr |=> $stable(r.count))
      else $error("counter moved without a tick");
   AST_MATCH_SETS_FLAG: assert property (match_a |=> r.flags[1])
      else $error("match a did not set its flag");
   AST_CAPTURE_COPIES: assert property (cap_edge && !top_from_cap && !wr |=> r.cap == $past(r.count) && r.flags[5])
      else $error("capture did not copy the counter");
   AST_FILTER_STEADY: assert property ($past(r.ctl_b[7]) && $rose(r.cap_level) |-> $past(&r.filt))
      else $error("filtered level rose on a spike");
   AST_TOP_WRAPS: assert property (tick && (kind == timer16_pkg::KIND_FAST) && at_top && !count_wr
                                   |=> r.count == 16'h0000 && r.flags[0])
      else $error("fast mode did not wrap at top");
   AST_MAX_OVERFLOW: assert property (tick && (wgm == 4'h0) && (r.count == 16'hffff) && !count_wr
                                      |=> r.count == 16'h0000 && r.flags[0])
      else $error("normal mode did not overflow at max");
   AST_WRITE_PRIORITY: assert property (count_wr |=> r.count == {$past(r.temp), $past(DAT_I)})
      else $error("counter write lost to counting");
   AST_IRQ_GATED: assert property (IRQ_MATCH_A == (r.flags[1] && r.mask[1]))
      else $error("match a request not flag and mask");
   AST_NO_PWM_A: assert property (ocra_top && r.ctl_a[7:6] == 2'h2 && !$past(r.ctl_a[7:6] == 2'h0)
                                  |=> $stable(r.wave_a))
      else $error("compare a made pwm while defining top");
   AST_ACK_ONE: assert property (req |=> ACK_O ##1 !ACK_O)
      else $error("ack not a single pulse");

endmodule

`default_nettype wire

// File: tb/cpu_bus_model.sv
// wishbone master standing in for the cpu core
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   input wire logic CLK,
   output logic CYC,
   output logic STB,
   output logic WE,
   output logic [3:0] ADR,
   output logic SEL,
   output logic [7:0] DAT_W,
   input wire logic [7:0] DAT_R,
   input wire logic ACK
);
   logic [7:0] q;
   // idle bus from time zero
   initial
   begin
      CYC = 1'b0;
      STB = 1'b0;
      WE = 1'b0;
      ADR = 4'h0;
      SEL = 1'b0;
      DAT_W = 8'h00;
   end
   // one classic cycle, held until ack is sampled
   task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge CLK);
      CYC <= 1'b1;
      STB <= 1'b1;
      WE <= wr;
      ADR <= a;
      SEL <= 1'b1;
      DAT_W <= d;
      do
         @(posedge CLK);
      while (ACK !== 1'b1);
      r = DAT_R;
      CYC <= 1'b0;
      STB <= 1'b0;
      WE <= 1'b0;
   endtask
   // word write, high byte first
   task automatic wr16(input logic [3:0] lo, input logic [3:0] hi, input logic [15:0] v);
      access(1'b1, hi, v[15:8], q);
      access(1'b1, lo, v[7:0], q);
   endtask
   // word read, low byte first
   task automatic rd16(input logic [3:0] lo, input logic [3:0] hi, output logic [15:0] v);
      access(1'b0, lo, 8'h00, v[7:0]);
      access(1'b0, hi, 8'h00, v[15:8]);
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_n, cyc, stb, we, sel, ack, ext_pin, cap_pin, cmp_in;
   logic wave_a, wave_b, irq_ovf, irq_ma, irq_mb, irq_cap;
   logic [3:0] adr;
   logic [7:0] dat_w, dat_r, b;
   logic [15:0] w;
   int errors, samples_checked;

   timer16 timer16_inst (.CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .EXT_COUNT_PIN(ext_pin),
      .CAPTURE_PIN(cap_pin), .COMPARATOR_IN(cmp_in), .WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b),
      .IRQ_OVERFLOW(irq_ovf), .IRQ_MATCH_A(irq_ma), .IRQ_MATCH_B(irq_mb), .IRQ_CAPTURE(irq_cap));
   cpu_bus_model cpu_bus_model_inst (.CLK(clk), .CYC(cyc), .STB(stb), .WE(we), .ADR(adr), .SEL(sel),
      .DAT_W(dat_w), .DAT_R(dat_r), .ACK(ack));

   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cpu_bus_model_inst.access(1'b1, a, d, b);
   endtask
   task automatic rd(input logic [3:0] a);
      cpu_bus_model_inst.access(1'b0, a, 8'h00, b);
   endtask
   task automatic cnt(input logic [15:0] v);
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CNT_LO, timer16_pkg::ADR_CNT_HI, v);
   endtask
   task automatic rd_cnt;
      cpu_bus_model_inst.rd16(timer16_pkg::ADR_CNT_LO, timer16_pkg::ADR_CNT_HI, w);
   endtask
   // n clean pulses on the count pin
   task automatic pulse_ext(input int n);
      repeat (n)
      begin
         @(posedge clk);
         ext_pin <= 1'b1;
         repeat (6) @(posedge clk);
         ext_pin <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask

   task automatic test_reset;
      rd(timer16_pkg::ADR_CTL_A);
      check("ctl_a", b, 16'h0000);
      rd(timer16_pkg::ADR_FLAGS);
      check("flags", b, 16'h0000);
      rd(4'hf);
      check("unmapped", b, 16'h0000);
      check("irqs", {irq_ovf, irq_ma, irq_mb, irq_cap}, 16'h0000);
   endtask

   // stopped counter holds a written word, pin ignored
   task automatic test_stopped;
      cnt(16'h1234);
      pulse_ext(2);
      rd_cnt;
      check("cnt stop", w, 16'h1234);
   endtask

   // both pin edges count exactly, power-off freezes
   task automatic test_ext_clock;
      cnt(16'h0010);
      wr(timer16_pkg::ADR_CTL_B, {5'h00, timer16_pkg::CS_EXT_RISE});
      pulse_ext(5);
      wr(timer16_pkg::ADR_CTL_B, {5'h00, timer16_pkg::CS_EXT_FALL});
      pulse_ext(3);
      rd_cnt;
      check("cnt ext", w, 16'h0018);
      wr(timer16_pkg::ADR_POWER, 8'h01);
      pulse_ext(3);
      wr(timer16_pkg::ADR_POWER, 8'h00);
      wr(timer16_pkg::ADR_CTL_B, 8'h00);
      rd_cnt;
      check("cnt pwr", w, 16'h0018);
   endtask

   // compare match sets flags, toggles wave a, masks gate irq
   task automatic test_match;
      wr(timer16_pkg::ADR_CTL_A, 8'h40);
      rd(timer16_pkg::ADR_CTL_A);
      check("ctl_a rw", b, 16'h0040);
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CMPA_LO, timer16_pkg::ADR_CMPA_HI, 16'h0005);
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CMPB_LO, timer16_pkg::ADR_CMPB_HI, 16'h0004);
      wr(timer16_pkg::ADR_MASK, 8'h02);
      cnt(16'h0003);
      wr(timer16_pkg::ADR_CTL_B, 8'h07);
      pulse_ext(3);
      wr(timer16_pkg::ADR_CTL_B, 8'h00);
      rd(timer16_pkg::ADR_FLAGS);
      check("flags ab", b, 16'h0006);
      check("irq ma mb", {irq_ma, irq_mb}, 16'h0002);
      check("waves", {wave_a, wave_b}, 16'h0002);
      wr(timer16_pkg::ADR_MASK, 8'h00);
      repeat (2) @(posedge clk);
      check("irq masked", irq_ma, 16'h0000);
      wr(timer16_pkg::ADR_MASK, 8'h02);
      wr(timer16_pkg::ADR_FLAGS, 8'h02);
      repeat (2) @(posedge clk);
      check("irq cleared", irq_ma, 16'h0000);
      rd(timer16_pkg::ADR_FLAGS);
      check("flags b", b, 16'h0004);
      wr(timer16_pkg::ADR_CTL_C, 8'h80);
      repeat (2) @(posedge clk);
      check("force a", wave_a, 16'h0000);
      rd(timer16_pkg::ADR_CTL_C);
      check("ctl_c", b, 16'h0000);
      cpu_bus_model_inst.rd16(timer16_pkg::ADR_CMPA_LO, timer16_pkg::ADR_CMPA_HI, w);
      check("cmp a", w, 16'h0005);
   endtask

   // wrap from max to bottom raises overflow
   task automatic test_overflow;
      wr(timer16_pkg::ADR_FLAGS, 8'hff);
      wr(timer16_pkg::ADR_MASK, 8'h01);
      cnt(16'hfffe);
      wr(timer16_pkg::ADR_CTL_B, 8'h07);
      pulse_ext(2);
      wr(timer16_pkg::ADR_CTL_B, 8'h00);
      rd(timer16_pkg::ADR_FLAGS);
      check("ovf flag", b, 16'h0001);
      check("irq ovf", irq_ovf, 16'h0001);
      rd_cnt;
      check("bottom", w, 16'h0000);
   endtask

   // capture from pin, comparator, and filtered spike
   task automatic cap_step(input logic [15:0] v, input logic [7:0] f);
      repeat (16) @(posedge clk);
      rd(timer16_pkg::ADR_FLAGS);
      check("cap flag", b, {8'h00, f});
      cpu_bus_model_inst.rd16(timer16_pkg::ADR_CAP_LO, timer16_pkg::ADR_CAP_HI, w);
      check("cap value", w, v);
      wr(timer16_pkg::ADR_FLAGS, 8'hff);
   endtask
   task automatic test_capture;
      wr(timer16_pkg::ADR_FLAGS, 8'hff);
      wr(timer16_pkg::ADR_MASK, 8'h20);
      wr(timer16_pkg::ADR_CTL_B, 8'h40);
      cnt(16'h0042);
      cap_pin <= 1'b1;
      cap_step(16'h0042, 8'h20);
      wr(timer16_pkg::ADR_CTL_C, 8'h01);
      cnt(16'h0077);
      cmp_in <= 1'b1;
      cap_step(16'h0077, 8'h20);
      cap_pin <= 1'b0;
      wr(timer16_pkg::ADR_CTL_C, 8'h00);
      wr(timer16_pkg::ADR_CTL_B, 8'hc0);
      cnt(16'h0099);
      cap_pin <= 1'b1;
      repeat (2) @(posedge clk);
      cap_pin <= 1'b0;
      cap_step(16'h0077, 8'h00);
      cap_pin <= 1'b1;
      repeat (16) @(posedge clk);
      check("irq cap", irq_cap, 16'h0001);
      cap_step(16'h0099, 8'h20);
   endtask

   // fast pwm with compare a as top: wrap, no pwm on a, buffered top
   task automatic test_pwm;
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CMPA_LO, timer16_pkg::ADR_CMPA_HI, 16'h0003);
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CMPB_LO, timer16_pkg::ADR_CMPB_HI, 16'h0001);
      cnt(16'h0000);
      wr(timer16_pkg::ADR_CTL_A, 8'ha3);
      wr(timer16_pkg::ADR_CTL_B, 8'h1f);
      pulse_ext(4);
      rd(timer16_pkg::ADR_FLAGS);
      check("pwm flags", b, 16'h0007);
      check("pwm waves", {wave_a, wave_b}, 16'h0001);
      cpu_bus_model_inst.wr16(timer16_pkg::ADR_CMPA_LO, timer16_pkg::ADR_CMPA_HI, 16'h0005);
      pulse_ext(4);
      wr(timer16_pkg::ADR_CTL_B, 8'h00);
      rd_cnt;
      check("pwm top buffered", w, 16'h0000);
   endtask

   task automatic final_report;
      if (errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report;
   end

   // reset then scenarios
   initial
   begin
      errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      ext_pin = 1'b0;
      cap_pin = 1'b0;
      cmp_in = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      test_reset;
      test_stopped;
      test_ext_clock;
      test_match;
      test_overflow;
      test_capture;
      test_pwm;
      final_report;
   end
endmodule
`default_nettype wire
